// file: core/dual_timer_cfg.svh
// Constants for the dual timer/counter block
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH

// ==========================================================
// Register addresses
`define ADDR_CTRL       8'h88
`define ADDR_MODE       8'h89
`define ADDR_A_LOW      8'h8a
`define ADDR_B_LOW      8'h8b
`define ADDR_A_HIGH     8'h8c
`define ADDR_B_HIGH     8'h8d

// ==========================================================
// Control register bits
`define CTRL_OVF_B      7
`define CTRL_RUN_B      6
`define CTRL_OVF_A      5
`define CTRL_RUN_A      4
`define CTRL_IRQ_B      3
`define CTRL_TRIG_B     2
`define CTRL_IRQ_A      1
`define CTRL_TRIG_A     0

// ==========================================================
// Mode register layout, timer B in upper nibble
`define MODE_B_LSB      4
`define MODE_A_LSB      0
`define MODE_GATE_BIT   3
`define MODE_CT_BIT     2
`define MODE_SEL_MSB    1

// ==========================================================
// Reset values and timing
`define CTRL_RESET      8'h00
`define MODE_RESET      8'h00
`define COUNT_RESET     8'h00
`define MCYC_PERIODS    4'hc
`define MCYC_LAST       4'hb
`define PRESC_MAX       5'h1f
`define BYTE_MAX        8'hff

`endif

// file: core/dual_timer_counter.sv
// Dual 16-bit timer/counter with external interrupt flags
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_cfg.svh"

module dual_timer_counter (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       vector_ovf_a_i,
  input  wire logic       vector_ovf_b_i,
  input  wire logic       vector_irq_a_i,
  input  wire logic       vector_irq_b_i,
  input  wire logic       count_pin_a_i,
  input  wire logic       count_pin_b_i,
  input  wire logic       ext_irq_pin_a_i,
  input  wire logic       ext_irq_pin_b_i,
  output logic            overflow_flag_a_o,
  output logic            overflow_flag_b_o,
  output logic            ext_irq_flag_a_o,
  output logic            ext_irq_flag_b_o
);

  // ========================================================
  // Decoding
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  logic [7:0] timer_ctrl_reg_r;
  logic [7:0] timer_mode_reg_r;
  logic [7:0] low_r  [2];
  logic [7:0] high_r [2];
  logic [7:0] low_nxt  [2];
  logic [7:0] high_nxt [2];
  logic [1:0] ovf_evt;
  logic       high_a_ovf;

  logic       wr_ctrl;
  logic       wr_mode;
  logic [1:0] wr_low;
  logic [1:0] wr_high;

  assign wr_ctrl    = sfr_wr_i && hit(sfr_addr_i, `ADDR_CTRL);
  assign wr_mode    = sfr_wr_i && hit(sfr_addr_i, `ADDR_MODE);
  assign wr_low[0]  = sfr_wr_i && hit(sfr_addr_i, `ADDR_A_LOW);
  assign wr_low[1]  = sfr_wr_i && hit(sfr_addr_i, `ADDR_B_LOW);
  assign wr_high[0] = sfr_wr_i && hit(sfr_addr_i, `ADDR_A_HIGH);
  assign wr_high[1] = sfr_wr_i && hit(sfr_addr_i, `ADDR_B_HIGH);

  // ========================================================
  // Pin synchronisers
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pins;

  assign pins = {ext_irq_pin_b_i, ext_irq_pin_a_i,
                 count_pin_b_i, count_pin_a_i};

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // Idle high, so no false edge after reset
      pin_s1_r <= 4'hf;
      pin_s2_r <= 4'hf;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ========================================================
  // Machine cycle divider
  logic [3:0] mcyc_cnt_r;
  logic       mcyc_tick;

  // First tick eleven edges after reset
  // Twelve clock cycle
  assign mcyc_tick = (mcyc_cnt_r == `MCYC_LAST);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mcyc_cnt_r <= 4'h0;
    end else if (mcyc_tick) begin
      mcyc_cnt_r <= 4'h0;
    end else begin
      mcyc_cnt_r <= mcyc_cnt_r + 4'h1;
    end
  end

  // ========================================================
  // Count pin sampling, once per machine cycle
  logic [1:0] cnt_samp_r;
  logic [1:0] cnt_fall_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_samp_r <= 2'h3;
      cnt_fall_r <= 2'h0;
    end else if (mcyc_tick) begin
      // Fall seen at one tick counts at the next
      // High then low sample
      cnt_samp_r <= pin_s2_r[1:0];
      cnt_fall_r <= cnt_samp_r & ~pin_s2_r[1:0];
    end
  end

  // ========================================================
  // Per timer count enables
  logic [1:0] inc_evt;

  generate
    for (genvar t = 0; t < 2; t++) begin : g_en
      localparam int LSB = (t == 0) ? `MODE_A_LSB : `MODE_B_LSB;
      localparam int RUN = (t == 0) ? `CTRL_RUN_A : `CTRL_RUN_B;
      logic gate_ok;
      logic src;
      // Gate pin low freezes the count
      // Gate against irq pin
      assign gate_ok = !timer_mode_reg_r[LSB + `MODE_GATE_BIT]
                       || pin_s2_r[2 + t];
      assign src = timer_mode_reg_r[LSB + `MODE_CT_BIT] ?
                   cnt_fall_r[t] : 1'b1;
      assign inc_evt[t] = mcyc_tick && timer_ctrl_reg_r[RUN]
                          && gate_ok && src;
    end
  endgenerate

  // ========================================================
  // Counter update
  dual_timer_pkg::timer_mode_t mode_a;
  dual_timer_pkg::timer_mode_t mode_b;

  assign mode_a = dual_timer_pkg::timer_mode_t'(
    timer_mode_reg_r[`MODE_A_LSB + `MODE_SEL_MSB -: 2]);
  assign mode_b = dual_timer_pkg::timer_mode_t'(
    timer_mode_reg_r[`MODE_B_LSB + `MODE_SEL_MSB -: 2]);

  always_comb begin
    dual_timer_pkg::timer_mode_t m;
    int t;
    m = dual_timer_pkg::MODE_PRESC13;
    t = 0;
    high_a_ovf = 1'b0;
    for (t = 0; t < 2; t++) begin
      low_nxt[t]  = low_r[t];
      high_nxt[t] = high_r[t];
      ovf_evt[t]  = 1'b0;
      m = (t == 0) ? mode_a : mode_b;
      if (inc_evt[t]) begin
        case (m)
          dual_timer_pkg::MODE_PRESC13: begin
            // Upper three low bits kept as written
            // Five bit prescaler
            low_nxt[t] = low_r[t] + 8'h01;
            if (low_r[t][4:0] == `PRESC_MAX) begin
              low_nxt[t]  = {low_r[t][7:5], 5'h00};
              high_nxt[t] = high_r[t] + 8'h01;
              ovf_evt[t]  = (high_r[t] == `BYTE_MAX);
            end
          end
          dual_timer_pkg::MODE_CASC16: begin
            low_nxt[t] = low_r[t] + 8'h01;
            if (low_r[t] == `BYTE_MAX) begin
              high_nxt[t] = high_r[t] + 8'h01;
              ovf_evt[t]  = (high_r[t] == `BYTE_MAX);
            end
          end
          dual_timer_pkg::MODE_RELOAD8: begin
            // High byte untouched by the reload
            // Reload from high byte
            if (low_r[t] == `BYTE_MAX) begin
              low_nxt[t] = high_r[t];
              ovf_evt[t] = 1'b1;
            end else begin
              low_nxt[t] = low_r[t] + 8'h01;
            end
          end
          dual_timer_pkg::MODE_SPLIT: begin
            // Timer B holds; timer A low byte alone
            if (t == 0) begin
              low_nxt[t] = low_r[t] + 8'h01;
              ovf_evt[t] = (low_r[t] == `BYTE_MAX);
            end
          end
          default: begin
            low_nxt[t] = low_r[t];
          end
        endcase
      end
    end
    // Split high byte counts cycles, no gate
    // Timer A high byte on B run bit
    if (mode_a == dual_timer_pkg::MODE_SPLIT && mcyc_tick
        && timer_ctrl_reg_r[`CTRL_RUN_B]) begin
      high_nxt[0] = high_r[0] + 8'h01;
      high_a_ovf  = (high_r[0] == `BYTE_MAX);
    end
  end

  // ========================================================
  // Count registers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int t = 0; t < 2; t++) begin
        low_r[t]  <= `COUNT_RESET;
        high_r[t] <= `COUNT_RESET;
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        low_r[t]  <= wr_low[t]  ? sfr_wdata_i : low_nxt[t];
        high_r[t] <= wr_high[t] ? sfr_wdata_i : high_nxt[t];
      end
    end
  end

  // ========================================================
  // Mode register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_mode_reg_r <= `MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_reg_r <= sfr_wdata_i;
    end
  end

  // ========================================================
  // External interrupt detection
  logic [1:0] irq_prev_r;
  logic [1:0] irq_set;
  logic [1:0] trig;
  logic       ovf_b_set;

  assign trig = {timer_ctrl_reg_r[`CTRL_TRIG_B],
                 timer_ctrl_reg_r[`CTRL_TRIG_A]};

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_prev_r <= 2'h3;
    end else begin
      irq_prev_r <= pin_s2_r[3:2];
    end
  end

  assign irq_set = (trig & irq_prev_r & ~pin_s2_r[3:2])
                 | (~trig & ~pin_s2_r[3:2]);

  // Timer B own overflow ignored while A is split
  // B flag taken by A high byte in split mode
  assign ovf_b_set = (mode_a == dual_timer_pkg::MODE_SPLIT) ?
                     high_a_ovf : ovf_evt[1];

  // ========================================================
  // Flag set and clear sources
  logic [1:0] ovf_set;
  logic [1:0] ovf_clr;
  logic [1:0] irq_clr;
  logic [1:0] irq_lvl_clr;

  assign ovf_set     = {ovf_b_set, ovf_evt[0]};
  assign ovf_clr     = {vector_ovf_b_i, vector_ovf_a_i};
  // Vector clears an edge-mode flag only
  assign irq_clr     = {vector_irq_b_i, vector_irq_a_i} & trig;
  // Level flag follows the pin; a write lasts one cycle
  assign irq_lvl_clr = ~trig & ~{2{wr_ctrl}};

  // ========================================================
  // Control register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_ctrl_reg_r <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        timer_ctrl_reg_r <= sfr_wdata_i;
      end
      if (ovf_set[0]) begin
        timer_ctrl_reg_r[`CTRL_OVF_A] <= 1'b1;
      end else if (ovf_clr[0]) begin
        timer_ctrl_reg_r[`CTRL_OVF_A] <= 1'b0;
      end
      if (ovf_set[1]) begin
        timer_ctrl_reg_r[`CTRL_OVF_B] <= 1'b1;
      end else if (ovf_clr[1]) begin
        timer_ctrl_reg_r[`CTRL_OVF_B] <= 1'b0;
      end
      // Irq flags, vector clear in edge mode only
      if (irq_set[0]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_A] <= 1'b1;
      end else if (irq_clr[0]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_A] <= 1'b0;
      end else if (irq_lvl_clr[0]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_A] <= 1'b0;
      end
      if (irq_set[1]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_B] <= 1'b1;
      end else if (irq_clr[1]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_B] <= 1'b0;
      end else if (irq_lvl_clr[1]) begin
        timer_ctrl_reg_r[`CTRL_IRQ_B] <= 1'b0;
      end
    end
  end

  // ========================================================
  // Read data
  // Follows the address each cycle, unmapped reads zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      case (sfr_addr_i)
        `ADDR_CTRL:   sfr_rdata_o <= timer_ctrl_reg_r;
        `ADDR_MODE:   sfr_rdata_o <= timer_mode_reg_r;
        `ADDR_A_LOW:  sfr_rdata_o <= low_r[0];
        `ADDR_B_LOW:  sfr_rdata_o <= low_r[1];
        `ADDR_A_HIGH: sfr_rdata_o <= high_r[0];
        `ADDR_B_HIGH: sfr_rdata_o <= high_r[1];
        default:      sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ========================================================
  // Status outputs
  assign overflow_flag_a_o = timer_ctrl_reg_r[`CTRL_OVF_A];
  assign overflow_flag_b_o = timer_ctrl_reg_r[`CTRL_OVF_B];
  assign ext_irq_flag_a_o  = timer_ctrl_reg_r[`CTRL_IRQ_A];
  assign ext_irq_flag_b_o  = timer_ctrl_reg_r[`CTRL_IRQ_B];

endmodule

`default_nettype wire

// file: core/dual_timer_pkg.sv
// Types for the dual timer/counter block
package dual_timer_pkg;
  typedef enum logic [1:0] {
    MODE_PRESC13 = 2'b00,
    MODE_CASC16  = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT   = 2'b11
  } timer_mode_t;
endpackage

// file: tb/dual_timer_counter_bench.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_bench;
  logic        core_clk_i;
  logic        reset_i;
  logic [7:0]  sfr_addr_i;
  logic        sfr_wr_i;
  logic [7:0]  sfr_wdata_i;
  logic [7:0]  sfr_rdata_o;
  logic [3:0]  vec;
  logic        overflow_flag_a_o;
  logic        overflow_flag_b_o;
  logic        ext_irq_flag_a_o;
  logic        ext_irq_flag_b_o;
  wire         vector_irq_a_i = vec[0];
  wire         vector_irq_b_i = vec[1];
  wire         vector_ovf_a_i = vec[2];
  wire         vector_ovf_b_i = vec[3];
  wire         count_pin_a_i;
  wire         count_pin_b_i;
  wire         ext_irq_pin_a_i;
  wire         ext_irq_pin_b_i;
  wire  [3:0]  flg = {overflow_flag_b_o, overflow_flag_a_o,
                      ext_irq_flag_b_o, ext_irq_flag_a_o};
  int          err_total;
  int          compares;
  int          seed;
  logic [7:0]  t, m, r, lo, hi;
  logic [15:0] e;
  dual_timer_counter dual_timer_counter_inst (.*);
  dual_timer_pins_model dual_timer_pins_model_inst (
    .core_clk_i      (core_clk_i),
    .count_pin_a_o   (count_pin_a_i),
    .count_pin_b_o   (count_pin_b_i),
    .ext_irq_pin_a_o (ext_irq_pin_a_i),
    .ext_irq_pin_b_o (ext_irq_pin_b_i)
  );
  always #4 core_clk_i = ~core_clk_i;
  initial begin
    core_clk_i = 1'b0;
    reset_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_wdata_i = 8'h00;
    vec = 4'h0;
    err_total = 0;
    compares = 0;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    @(posedge core_clk_i);
    #1 chk(sfr_rdata_o, x);
  endtask
  task automatic wait_flg(input int i, input logic v);
    int n;
    n = 0;
    #1;
    while (flg[i] !== v && n < 400) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk({7'h00, flg[i]}, {7'h00, v});
  endtask
  task automatic vector(input int i);
    @(posedge core_clk_i);
    vec[i] <= 1'b1;
    @(posedge core_clk_i);
    vec[i] <= 1'b0;
    @(posedge core_clk_i);
    #1 chk({7'h00, flg[i]}, 8'h00);
  endtask
  // Low and high byte just after the first overflow
  function automatic logic [15:0] after_ovf(input logic [7:0] md, rn, l, h);
    if (rn[6]) return {l, 8'h00};
    case (md[1:0])
      2'b00:   return {l & 8'he0, 8'h00};
      2'b01:   return 16'h0000;
      2'b10:   return {h, h};
      default: return {8'h00, h};
    endcase
  endfunction
  task automatic report_and_stop;
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    report_and_stop;
  end
  initial begin
    seed = 32'h6218;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_reg(8'h88, 8'h00);
    rd_reg(8'h89, 8'h00);
    for (int i = 0; i < 5; i++) begin
      t = $random(seed);
      wr_reg(8'h89 + i[7:0], t);
      rd_reg(8'h89 + i[7:0], t);
    end
    wr_reg(8'h8e, 8'h5a);
    rd_reg(8'h8e, 8'h00);
    for (int i = 0; i < 5; i++) begin
      r = (i == 4) ? 8'h40 : 8'h10;
      m = (i == 4) ? 8'h03 : i[7:0];
      lo = (i == 0) ? ($random(seed) | 8'h1f) : 8'hff;
      hi = i[1] ? $random(seed) : 8'hff;
      wr_reg(8'h89, m);
      wr_reg(8'h8a, lo);
      wr_reg(8'h8c, hi);
      wr_reg(8'h88, r);
      wait_flg(r[6] ? 3 : 2, 1'b1);
      // Stop the timer but keep its flag for the vector check
      wr_reg(8'h88, r[6] ? 8'h80 : 8'h20);
      e = after_ovf(m, r, lo, hi);
      rd_reg(8'h8a, e[15:8]);
      rd_reg(8'h8c, e[7:0]);
      vector(r[6] ? 3 : 2);
    end
    for (int g = 0; g < 2; g++) begin
      wr_reg(8'h8a, 8'hff);
      wr_reg(8'h8c, 8'hff);
      wr_reg(8'h89, g ? 8'h09 : 8'h05);
      dual_timer_pins_model_inst.set_irq(0, g ? 1'b0 : 1'b1);
      wr_reg(8'h88, 8'h10);
      repeat (60) @(posedge core_clk_i);
      wait_flg(0, g[0]);
      wait_flg(2, 1'b0);
      if (g) dual_timer_pins_model_inst.set_irq(0, 1'b1);
      else dual_timer_pins_model_inst.pulse_cnt(0);
      wait_flg(2, 1'b1);
      wait_flg(0, 1'b0);
      wr_reg(8'h88, 8'h20);
      vector(2);
    end
    wr_reg(8'h8b, 8'hff);
    wr_reg(8'h89, 8'h30);
    wr_reg(8'h88, 8'h40);
    repeat (60) @(posedge core_clk_i);
    wait_flg(3, 1'b0);
    rd_reg(8'h8b, 8'hff);
    wr_reg(8'h88, 8'h05);
    for (int i = 0; i < 2; i++) begin
      dual_timer_pins_model_inst.set_irq(i, 1'b0);
      dual_timer_pins_model_inst.set_irq(i, 1'b1);
      wait_flg(i, 1'b1);
      repeat (6) @(posedge core_clk_i);
      vector(i);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: tb/dual_timer_counter_monitor.sv
// Port checker for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module dual_timer_counter_monitor (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       vector_ovf_a_i,
  input wire logic       vector_ovf_b_i,
  input wire logic       vector_irq_a_i,
  input wire logic       vector_irq_b_i,
  input wire logic       count_pin_a_i,
  input wire logic       count_pin_b_i,
  input wire logic       ext_irq_pin_a_i,
  input wire logic       ext_irq_pin_b_i,
  input wire logic       overflow_flag_a_o,
  input wire logic       overflow_flag_b_o,
  input wire logic       ext_irq_flag_a_o,
  input wire logic       ext_irq_flag_b_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] ctl_r;
  logic [7:0] mode_r;
  wire  [3:0] flg = {overflow_flag_b_o, overflow_flag_a_o,
                     ext_irq_flag_b_o, ext_irq_flag_a_o};
  // ==========================================================
  // Shadow of software-written bits
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl_r  <= 8'h00;
      mode_r <= 8'h00;
    end else if (sfr_wr_i && sfr_addr_i == 8'h88) begin
      ctl_r  <= sfr_wdata_i;
    end else if (sfr_wr_i && sfr_addr_i == 8'h89) begin
      mode_r <= sfr_wdata_i;
    end
  end
  // ==========================================================
  // Assertions
  a_level_flag_set: assert property (
    (!ctl_r[0] && !ext_irq_pin_a_i)[*4] |=> ext_irq_flag_a_o)
    else $error("level request not flagged");
  a_level_flag_clear: assert property (
    (!ctl_r[2] && ext_irq_pin_b_i && !sfr_wr_i)[*4] |=> !ext_irq_flag_b_o)
    else $error("level flag not withdrawn");
  a_edge_flag_set: assert property (
    ctl_r[0] && $fell(ext_irq_pin_a_i) ##1
    (!vector_irq_a_i && !sfr_wr_i)[*3] |=> ext_irq_flag_a_o)
    else $error("falling edge not flagged");
  a_edge_vector_clr: assert property (
    (ctl_r[2] && ext_irq_pin_b_i)[*4] ##0 (vector_irq_b_i && !sfr_wr_i)
    |=> !ext_irq_flag_b_o)
    else $error("edge flag kept after vector");
  a_ovf_vector_clr: assert property (
    (!ctl_r[6] && !ctl_r[4])[*2] ##0 (vector_ovf_b_i && !sfr_wr_i)
    |=> !overflow_flag_b_o)
    else $error("overflow flag kept after vector");
  a_ovf_idle_hold: assert property (
    (!ctl_r[4] && !sfr_wr_i)[*3] |=> !$rose(overflow_flag_a_o))
    else $error("overflow while stopped");
  a_ctrl_flags_read: assert property (
    sfr_addr_i == 8'h88 |=> {sfr_rdata_o[7], sfr_rdata_o[5],
    sfr_rdata_o[3], sfr_rdata_o[1]} == $past(flg))
    else $error("flag bits misplaced");
  a_unmapped_zero: assert property (
    sfr_addr_i[7:4] != 4'h8 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (
    sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(mode_r))
    else $error("mode readback wrong");
endmodule
bind dual_timer_counter dual_timer_counter_monitor
  dual_timer_counter_monitor_inst (.*);
`default_nettype wire

// file: tb/dual_timer_pins_model.sv
// Pin-side model: count pins and interrupt/gate pins
`timescale 1ns/10ps
`default_nettype none
module dual_timer_pins_model (
  input  wire logic core_clk_i,
  output logic      count_pin_a_o,
  output logic      count_pin_b_o,
  output logic      ext_irq_pin_a_o,
  output logic      ext_irq_pin_b_o
);
  logic [1:0] cnt_r;
  logic [1:0] irq_r;
  // Pull-ups hold the pins high when idle
  initial begin
    cnt_r = 2'b11;
    irq_r = 2'b11;
  end
  assign count_pin_a_o   = cnt_r[0];
  assign count_pin_b_o   = cnt_r[1];
  assign ext_irq_pin_a_o = irq_r[0];
  assign ext_irq_pin_b_o = irq_r[1];
  // Each level held for two machine cycles
  task automatic pulse_cnt(input int i);
    @(posedge core_clk_i);
    cnt_r[i] <= 1'b0;
    repeat (24) @(posedge core_clk_i);
    cnt_r[i] <= 1'b1;
    repeat (24) @(posedge core_clk_i);
  endtask
  task automatic set_irq(input int i, input logic v);
    @(posedge core_clk_i);
    irq_r[i] <= v;
  endtask
endmodule
`default_nettype wire
